// ==== design/sdbp_pkg.sv ====
// constants and carrier types for the serial dma buffer-pointer block
// assumes a 16-bit register port addressed by byte offset
package sdbp_pkg;
	localparam int unsigned DATA_W     = 16;
	localparam int unsigned PTR_W      = 13;
	localparam int unsigned BYTE_W     = 8;
	localparam int unsigned FIFO_DEPTH = 16;

	// register byte offsets
	localparam logic [15:0] OFS_RX_A_START   = 16'h4400;
	localparam logic [15:0] OFS_RX_A_END     = 16'h4402;
	localparam logic [15:0] OFS_RX_B_START   = 16'h4404;
	localparam logic [15:0] OFS_RX_B_END     = 16'h4406;
	localparam logic [15:0] OFS_TX_A_START   = 16'h4408;
	localparam logic [15:0] OFS_TX_A_END     = 16'h440A;
	localparam logic [15:0] OFS_TX_B_START   = 16'h440C;
	localparam logic [15:0] OFS_TX_B_END     = 16'h440E;
	localparam logic [15:0] OFS_RX_A_OFFSET  = 16'h4410;
	localparam logic [15:0] OFS_RX_B_OFFSET  = 16'h4412;
	localparam logic [15:0] OFS_TX_ACT_OFS   = 16'h4414;
	localparam logic [15:0] OFS_DMA_STATUS   = 16'h4416;
	localparam logic [15:0] OFS_DMA_CTRL     = 16'h4418;

	// fixed top bits of every start/end register, bits 15..13
	localparam logic [2:0]  ADDR_TOP_BITS    = 3'h3;
	localparam logic [12:0] ADDR_RESET       = 13'h0000;
	localparam logic [12:0] OFFSET_RESET     = 13'h0000;
	localparam logic [12:0] OFFSET_STEP      = 13'h0001;

	// control register fields
	localparam int unsigned CTRL_RX_A_LOAD   = 0;
	localparam int unsigned CTRL_RX_B_LOAD   = 1;
	localparam int unsigned CTRL_TX_A_LOAD   = 2;
	localparam int unsigned CTRL_TX_B_LOAD   = 3;
	localparam int unsigned CTRL_RX_RST      = 4;
	localparam int unsigned CTRL_TX_RST      = 5;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [15:0] wrData;
	} sdbp_bus_req_t;

	typedef struct packed {
		logic        wrEn;
		logic        rdEn;
		logic [12:0] addr;
		logic [7:0]  wrData;
	} sdbp_ram_req_t;
endpackage

// ==== design/sdbp_buffer_pointers.sv ====
// serial dma buffer pointers: address registers, offset counters,
// receive fifo and ram request logic
// assumes ram read data one cycle after rdEn, and ram that never stalls
`timescale 1ns/1ps

module sdbp_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 16
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// fill side
	input  wire logic             inValid,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  inReady,
	// drain side
	output logic                  outValid,
	output logic      [WIDTH-1:0] outData,
	input  wire logic             outReady
);
	localparam int unsigned PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wrPtr_reg;
	logic [PW-1:0]    rdPtr_reg;
	logic [PW:0]      count_reg;

	wire logic push = inValid && inReady;
	wire logic pop  = outValid && outReady;

	assign inReady  = count_reg != (PW+1)'(DEPTH);
	assign outValid = count_reg != '0;
	assign outData  = mem[rdPtr_reg];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr_reg] <= inData;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end else begin
			wrPtr_reg <= push ? wrPtr_reg + 1'b1 : wrPtr_reg;
			rdPtr_reg <= pop ? rdPtr_reg + 1'b1 : rdPtr_reg;
			count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule // sdbp_fifo

// Notes on behaviour
// - read-only byte offset counter for rx buffer B
// - read-only byte offset for active tx buffer
// - counter returns to zero when buffer unloads
// - writable start address for rx A and B
// - writable end address for rx A and B
// - writable start address for tx A and B
// - writable end address for tx A and B
// - address bits 14,13 read one, 15 zero
// - offset counters read-only, reset to zero
// - load bit starts dma, reads one, self-clears
// - matching read-only offset counter for rx A
module sdbp_buffer_pointers (
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	// register port
	input  wire sdbp_pkg::sdbp_bus_req_t busReq,
	output logic                 [15:0] busRdData,
	// received bytes from the serial controller
	input  wire logic                   rxValid,
	input  wire logic            [7:0]  rxData,
	output logic                        rxReady,
	// bytes to transmit towards the serial controller
	output logic                        txValid,
	output logic                 [7:0]  txData,
	input  wire logic                   txReady,
	// on-chip ram
	output sdbp_pkg::sdbp_ram_req_t     ramReq,
	input  wire logic            [7:0]  ramRdData
);
	import sdbp_pkg::*;

	// index 0..7: rx A start/end, rx B, tx A, tx B
	logic [12:0] addrReg_reg [8];
	logic [1:0]  rxLoad_reg;
	logic [1:0]  txLoad_reg;
	logic        rxCur_reg;
	logic        txCur_reg;
	logic [12:0] rxOffA_reg;
	logic [12:0] rxOffB_reg;
	logic [12:0] txOff_reg;
	logic        txPend_reg;
	logic        txValid_reg;
	logic [7:0]  txData_reg;
	logic [15:0] rdData_reg;

	function automatic logic isAddrReg(input logic [15:0] a);
		return a[15:4] == OFS_RX_A_START[15:4] && !a[0];
	endfunction

	// register port decode
	wire logic [2:0] regIdx    = busReq.addr[3:1];
	wire logic       wrAddrReg = busReq.wr && isAddrReg(busReq.addr);
	wire logic       wrCtrl    = busReq.wr && busReq.addr == OFS_DMA_CTRL;
	wire logic       rxRst     = wrCtrl && busReq.wrData[CTRL_RX_RST];
	wire logic       txRst     = wrCtrl && busReq.wrData[CTRL_TX_RST];
	// writing zero to a load bit has no effect
	wire logic [1:0] rxLoadSet = wrCtrl ?
		busReq.wrData[CTRL_RX_B_LOAD:CTRL_RX_A_LOAD] : 2'h0;
	wire logic [1:0] txLoadSet = wrCtrl ?
		busReq.wrData[CTRL_TX_B_LOAD:CTRL_TX_A_LOAD] : 2'h0;

	// receive side
	wire logic        fifoOutValid;
	wire logic [7:0]  fifoOutData;
	wire logic        rxActive   = rxLoad_reg[rxCur_reg];
	wire logic [12:0] rxOffCur   = rxCur_reg ? rxOffB_reg : rxOffA_reg;
	wire logic [12:0] rxStart    = addrReg_reg[{1'b0, rxCur_reg, 1'b0}];
	wire logic [12:0] rxEnd      = addrReg_reg[{1'b0, rxCur_reg, 1'b1}];
	wire logic [12:0] rxByteAddr = rxStart + rxOffCur;
	wire logic        rxDrain    = rxActive && !rxRst;
	wire logic        rxWrite    = rxDrain && fifoOutValid;
	wire logic        rxDone     = rxWrite && rxByteAddr == rxEnd;
	wire logic [1:0]  rxDoneMask = rxDone ? {rxCur_reg, !rxCur_reg} : 2'h0;
	wire logic        rxOther    = rxLoad_reg[!rxCur_reg];

	// transmit side
	wire logic        txActive   = txLoad_reg[txCur_reg];
	wire logic [12:0] txStart    = addrReg_reg[{1'b1, txCur_reg, 1'b0}];
	wire logic [12:0] txEnd      = addrReg_reg[{1'b1, txCur_reg, 1'b1}];
	wire logic [12:0] txByteAddr = txStart + txOff_reg;
	// rx owns the ram port first: a stalled rx fifo loses bytes upstream
	wire logic        txIssue    = txActive && !txPend_reg && !txValid_reg
		&& !rxWrite && !txRst;
	wire logic        txDone     = txIssue && txByteAddr == txEnd;
	wire logic [1:0]  txDoneMask = txDone ? {txCur_reg, !txCur_reg} : 2'h0;
	wire logic        txOther    = txLoad_reg[!txCur_reg];

	// set from software wins over completion in the same cycle
	wire logic [1:0] rxLoad_next = rxRst ? rxLoadSet :
		(rxLoad_reg & ~rxDoneMask) | rxLoadSet;
	wire logic [1:0] txLoad_next = txRst ? txLoadSet :
		(txLoad_reg & ~txDoneMask) | txLoadSet;
	wire logic rxCur_next = rxRst ? 1'b0 :
		(rxDone || (!rxActive && rxOther)) ? !rxCur_reg :
		rxCur_reg;
	wire logic txCur_next = txRst ? 1'b0 :
		(txDone || (!txActive && txOther)) ? !txCur_reg :
		txCur_reg;

	wire logic [12:0] rxOffA_next =
		(rxRst || (rxDone && !rxCur_reg)) ? OFFSET_RESET :
		(rxWrite && !rxCur_reg) ? rxOffA_reg + OFFSET_STEP :
		rxOffA_reg;
	wire logic [12:0] rxOffB_next =
		(rxRst || (rxDone && rxCur_reg)) ? OFFSET_RESET :
		(rxWrite && rxCur_reg) ? rxOffB_reg + OFFSET_STEP :
		rxOffB_reg;
	wire logic [12:0] txOff_next =
		(txRst || txDone) ? OFFSET_RESET :
		txIssue ? txOff_reg + OFFSET_STEP :
		txOff_reg;

	// read-back selection; counters ignore writes entirely
	wire logic [15:0] addrRead   = {ADDR_TOP_BITS, addrReg_reg[regIdx]};
	wire logic [15:0] statusRead = {12'h000,
		txLoad_reg[1] && txCur_reg, txLoad_reg[0] && !txCur_reg,
		rxLoad_reg[1] && rxCur_reg, rxLoad_reg[0] && !rxCur_reg};
	wire logic [15:0] rdMux =
		isAddrReg(busReq.addr) ? addrRead :
		busReq.addr == OFS_RX_A_OFFSET ? {3'h0, rxOffA_reg} :
		busReq.addr == OFS_RX_B_OFFSET ? {3'h0, rxOffB_reg} :
		busReq.addr == OFS_TX_ACT_OFS  ? {3'h0, txOff_reg} :
		busReq.addr == OFS_DMA_STATUS  ? statusRead :
		busReq.addr == OFS_DMA_CTRL    ? {12'h000, txLoad_reg, rxLoad_reg} :
		16'h0000;

	sdbp_fifo #(
		.WIDTH (BYTE_W),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.clk      (clk),
		.rst_n    (rst_n),
		.inValid  (rxValid),
		.inData   (rxData),
		.inReady  (rxReady),
		.outValid (fifoOutValid),
		.outData  (fifoOutData),
		.outReady (rxDrain)
	);

	// only bits 12..0 are stored; the top three are constants
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_addr
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					addrReg_reg[g] <= ADDR_RESET;
				end else if (wrAddrReg && regIdx == 3'(g)) begin
					addrReg_reg[g] <= busReq.wrData[12:0];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rxLoad_reg <= 2'h0;
			txLoad_reg <= 2'h0;
			rxCur_reg  <= 1'b0;
			txCur_reg  <= 1'b0;
			rxOffA_reg <= OFFSET_RESET;
			rxOffB_reg <= OFFSET_RESET;
			txOff_reg  <= OFFSET_RESET;
		end else begin
			rxLoad_reg <= rxLoad_next;
			txLoad_reg <= txLoad_next;
			rxCur_reg  <= rxCur_next;
			txCur_reg  <= txCur_next;
			rxOffA_reg <= rxOffA_next;
			rxOffB_reg <= rxOffB_next;
			txOff_reg  <= txOff_next;
		end
	end

	// one-byte output stage; next fetch waits until it drains
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			txPend_reg  <= 1'b0;
			txValid_reg <= 1'b0;
			txData_reg  <= 8'h00;
		end else begin
			txPend_reg  <= txIssue;
			if (txRst) begin
				txValid_reg <= 1'b0;
			end else if (txPend_reg) begin
				txValid_reg <= 1'b1;
				txData_reg  <= ramRdData;
			end else if (txReady) begin
				txValid_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdData_reg <= 16'h0000;
		end else if (busReq.rd) begin
			rdData_reg <= rdMux;
		end
	end

	assign busRdData     = rdData_reg;
	assign txValid       = txValid_reg;
	assign txData        = txData_reg;
	assign ramReq.wrEn   = rxWrite;
	assign ramReq.rdEn   = txIssue;
	assign ramReq.addr   = rxWrite ? rxByteAddr : txByteAddr;
	assign ramReq.wrData = fifoOutData;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_tx_fetch;
		txIssue && !txRst;
	endsequence
	// a dma reset in the pending cycle legally drops the byte
	sequence s_tx_present;
		txPend_reg && !txRst;
	endsequence

	a_fixed_top_bits: assert property (
		busReq.rd && isAddrReg(busReq.addr) |=> busRdData[15:13] == 3'h3)
		else $error("address register top bits wrong");
	a_addr_store: assert property (
		wrAddrReg && regIdx == 3'h2 |=>
		addrReg_reg[2] == $past(busReq.wrData[12:0]))
		else $error("rx B start not stored");
	a_rxb_advance: assert property (
		rxWrite && rxCur_reg && !rxDone |=>
		rxOffB_reg == $past(rxOffB_reg) + OFFSET_STEP)
		else $error("rx B offset did not advance");
	a_rxb_wrap: assert property (
		rxDone && rxCur_reg && !rxLoadSet[1] |=>
		rxOffB_reg == OFFSET_RESET && !rxLoad_reg[1] && !rxCur_reg)
		else $error("rx B did not unload and wrap");
	a_rxa_wrap: assert property (
		rxDone && !rxCur_reg |=> rxOffA_reg == OFFSET_RESET && rxCur_reg)
		else $error("rx A did not wrap and switch");
	a_cnt_reset: assert property (
		rxRst |=> rxOffA_reg == OFFSET_RESET && rxOffB_reg == OFFSET_RESET)
		else $error("rx offsets not cleared by dma reset");
	a_cnt_readonly: assert property (
		busReq.wr && busReq.addr == OFS_TX_ACT_OFS && !txIssue && !txRst
		|=> txOff_reg == $past(txOff_reg))
		else $error("tx offset changed by a write");
	a_load_set: assert property (
		wrCtrl && busReq.wrData[CTRL_TX_A_LOAD] ##1 busReq.rd
		&& busReq.addr == OFS_DMA_CTRL |=> busRdData[CTRL_TX_A_LOAD])
		else $error("tx A load bit not reading one");
	a_tx_fetch: assert property (
		s_tx_fetch |-> ramReq.rdEn && ramReq.addr == txStart + txOff_reg
		##1 txPend_reg)
		else $error("tx fetch not issued to ram");
	a_tx_present: assert property (
		s_tx_fetch ##1 s_tx_present |=> txValid_reg)
		else $error("tx fetch did not reach output stage");
	a_tx_unload: assert property (
		txDone && !txLoadSet[txCur_reg] |=>
		txOff_reg == OFFSET_RESET && !txLoad_reg[$past(txCur_reg)])
		else $error("tx buffer not unloaded at end address");
endmodule // sdbp_buffer_pointers

// ==== bench/sdbp_ram_model.sv ====
// on-chip ram seen by the dma: 8k bytes, one-cycle read latency
// assumes one request per cycle; bench may preload mem directly
`timescale 1ns/1ps

module sdbp_ram_model (
	// clock
	input  wire logic                  clk,
	// dma request and read data
	input  wire sdbp_pkg::sdbp_ram_req_t ramReq,
	output logic                [7:0]  ramRdData
);
	import sdbp_pkg::*;

	logic [7:0] mem [0:8191];

	initial begin
		ramRdData = 8'h00;
	end

	// data is only good the cycle after rdEn; it toggles otherwise so a
	// late or early sample cannot pass by luck
	always @(posedge clk) begin
		if (ramReq.wrEn) begin
			mem[ramReq.addr] <= ramReq.wrData;
		end
		if (ramReq.rdEn) begin
			ramRdData <= mem[ramReq.addr];
		end else begin
			ramRdData <= ~ramRdData;
		end
	end
endmodule // sdbp_ram_model

// ==== bench/tb_top.sv ====
// bench for the dma buffer-pointer block: registers, rx fill, tx drain
// assumes the ram model beside the design and a 250 MHz clock
`timescale 1ns/1ps

module tb_top;
	import sdbp_pkg::*;

	logic          clk;
	logic          rst_n;
	sdbp_bus_req_t busReq;
	logic [15:0]   busRdData;
	logic          rxValid;
	logic [7:0]    rxData;
	logic          rxReady;
	logic          txValid;
	logic [7:0]    txData;
	logic          txReady;
	sdbp_ram_req_t ramReq;
	logic [7:0]    ramRdData;
	int            badCount;
	int            testsRun;
	int            taken;

	sdbp_buffer_pointers sdbp_buffer_pointers_inst (
		.clk(clk), .rst_n(rst_n), .busReq(busReq), .busRdData(busRdData),
		.rxValid(rxValid), .rxData(rxData), .rxReady(rxReady),
		.txValid(txValid), .txData(txData), .txReady(txReady),
		.ramReq(ramReq), .ramRdData(ramRdData));

	sdbp_ram_model sdbp_ram_model_inst (
		.clk(clk), .ramReq(ramReq), .ramRdData(ramRdData));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", testsRun, badCount);
		if (badCount == 0 && testsRun > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] exp,
			input logic [15:0] got);
		testsRun++;
		if (got !== exp) begin
			badCount++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// a gap cycle after each strobe keeps every drive to one per step
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		busReq.wr <= 1'b1;
		busReq.addr <= a;
		busReq.wrData <= d;
		@(posedge clk);
		busReq.wr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rdChk(input string what, input logic [15:0] a,
			input logic [15:0] exp);
		busReq.rd <= 1'b1;
		busReq.addr <= a;
		@(posedge clk);
		busReq.rd <= 1'b0;
		@(negedge clk);
		check(what, exp, busRdData);
		@(posedge clk);
	endtask

	// offers bytes until n are taken or the fifo refuses
	task automatic push(input int n, input logic [7:0] base, output int k);
		k = 0;
		rxValid <= 1'b1;
		rxData <= base;
		while (k < n) begin
			@(negedge clk);
			if (rxReady !== 1'b1) begin
				@(posedge clk);
				break;
			end
			@(posedge clk);
			k++;
			rxData <= base + 8'(k);
		end
		rxValid <= 1'b0;
	endtask

	task automatic take(input logic [7:0] exp);
		@(negedge clk);
		while (txValid !== 1'b1) @(negedge clk);
		check("txData", {8'h00, exp}, {8'h00, txData});
		@(posedge clk);
		txReady <= 1'b1;
		@(posedge clk);
		txReady <= 1'b0;
	endtask

	initial begin
		rst_n = 1'b0;
		busReq = '0;
		rxValid = 1'b0;
		rxData = 8'h00;
		txReady = 1'b0;
		badCount = 0;
		testsRun = 0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 8; i++) begin
			rdChk("addr rst", OFS_RX_A_START + 16'(2*i), 16'h6000);
		end
		for (int i = 0; i < 3; i++) begin
			rdChk("ofs rst", OFS_RX_A_OFFSET + 16'(2*i), 16'h0000);
		end
		for (int i = 0; i < 8; i++) begin
			wr(OFS_RX_A_START + 16'(2*i), 16'hFFFF);
			rdChk("addr", OFS_RX_A_START + 16'(2*i), 16'h7FFF);
		end
		wr(OFS_RX_B_OFFSET, 16'hFFFF);
		rdChk("ofs ro", OFS_RX_B_OFFSET, 16'h0000);
		rdChk("unmapped", 16'h4420, 16'h0000);
		// nothing loaded yet, so the fifo has to refuse byte 17
		push(20, 8'h80, taken);
		check("fifo depth", 16'h0010, 16'(taken));
		wr(OFS_RX_A_START, 16'h0040);
		wr(OFS_RX_A_END, 16'h004D);
		wr(OFS_RX_B_START, 16'h0060);
		wr(OFS_RX_B_END, 16'h0062);
		wr(OFS_DMA_CTRL, 16'h0003);
		repeat (40) @(posedge clk);
		rdChk("rx b ofs", OFS_RX_B_OFFSET, 16'h0002);
		rdChk("rx a ofs", OFS_RX_A_OFFSET, 16'h0000);
		rdChk("loads", OFS_DMA_CTRL, 16'h0002);
		rdChk("status", OFS_DMA_STATUS, 16'h0002);
		check("ram 40", 16'h0080, {8'h00, sdbp_ram_model_inst.mem[16'h40]});
		check("ram 4D", 16'h008D, {8'h00, sdbp_ram_model_inst.mem[16'h4D]});
		check("ram 61", 16'h008F, {8'h00, sdbp_ram_model_inst.mem[16'h61]});
		push(1, 8'h90, taken);
		repeat (8) @(posedge clk);
		check("ram 62", 16'h0090, {8'h00, sdbp_ram_model_inst.mem[16'h62]});
		rdChk("rx b wrap", OFS_RX_B_OFFSET, 16'h0000);
		rdChk("loads", OFS_DMA_CTRL, 16'h0000);
		sdbp_ram_model_inst.mem[16'h30] = 8'hA5;
		sdbp_ram_model_inst.mem[16'h31] = 8'h5A;
		wr(OFS_TX_A_START, 16'h0030);
		wr(OFS_TX_A_END, 16'h0031);
		wr(OFS_DMA_CTRL, 16'h0004);
		repeat (8) @(posedge clk);
		rdChk("tx ofs", OFS_TX_ACT_OFS, 16'h0001);
		take(8'hA5);
		take(8'h5A);
		repeat (4) @(posedge clk);
		rdChk("tx wrap", OFS_TX_ACT_OFS, 16'h0000);
		rdChk("loads", OFS_DMA_CTRL, 16'h0000);
		// rx dma reset clears a half-filled buffer's offset and load
		wr(OFS_DMA_CTRL, 16'h0001);
		push(1, 8'hC0, taken);
		repeat (4) @(posedge clk);
		check("ram 40 again", 16'h00C0, {8'h00, sdbp_ram_model_inst.mem[16'h40]});
		rdChk("rx a part", OFS_RX_A_OFFSET, 16'h0001);
		wr(OFS_DMA_CTRL, 16'h0010);
		rdChk("rx rst ofs", OFS_RX_A_OFFSET, 16'h0000);
		rdChk("rx rst loads", OFS_DMA_CTRL, 16'h0000);
		close_out();
	end

	// the whole run needs well under 2000 cycles
	initial begin
		repeat (20000) @(posedge clk);
		badCount++;
		$display("mismatch watchdog expected finish seen hang");
		close_out();
	end
endmodule // tb_top
